//--- pkg/chan_bus_if.sv
// carrier between the host front end and the channel register sets
interface chan_bus_if;
  import uart_front_pkg::*;
  logic [NUM_CH-1:0] wr;
  logic [NUM_CH-1:0] rd;
  logic [REG_AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [NUM_CH-1:0][DW-1:0] rdata;
  logic [NUM_CH-1:0] pend;
  logic [NUM_CH-1:0] soft_rst;
  logic strap_load;
  logic strap;
  modport hub (output wr, rd, addr, wdata, soft_rst, strap_load, strap,
    input rdata, pend);
  modport chan (input wr, rd, addr, wdata, soft_rst, strap_load, strap,
    output rdata, pend);
endinterface

//--- pkg/uart_front_pkg.sv
// shared constants for the octal uart host front end
package uart_front_pkg;
  localparam int NUM_CH = 8;
  localparam int DW = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int TMR_W = 16;
  // host address fields
  localparam int ADDR_W = 8;
  localparam int ADDR_CFG_BIT = 7;
  localparam int ADDR_CH_HI = 6;
  localparam int ADDR_CH_LO = 4;
  localparam int REG_AW = 4;
  // channel register offsets
  localparam logic [3:0] CH_DATA = 4'h0;
  localparam logic [3:0] CH_MCR = 4'h1;
  localparam logic [3:0] CH_FEATURE_CONTROL_REG = 4'h2;
  localparam logic [3:0] CH_MSR = 4'h3;
  localparam logic [3:0] CH_LSR = 4'h4;
  // modem, feature control and line status fields
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_IR = 6;
  localparam int MCR_PSC = 7;
  localparam int FEATURE_CONTROL_REG_RXINV = 4;
  localparam int LSR_RXRDY = 0;
  localparam int LSR_TXFULL = 1;
  localparam int LSR_TXEMPTY = 5;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] FEATURE_CONTROL_REG_RST = 8'h00;
  localparam logic [1:0] PSC_DIV4_LAST = 2'h3;
  // device configuration offsets and fields
  localparam logic [3:0] CFG_INT0 = 4'h0;
  localparam logic [3:0] CFG_INT1 = 4'h1;
  localparam logic [3:0] CFG_INT2 = 4'h2;
  localparam logic [3:0] CFG_INT3 = 4'h3;
  localparam logic [3:0] CFG_TMR_CTL = 4'h4;
  localparam logic [3:0] CFG_TMR_LSB = 4'h5;
  localparam logic [3:0] CFG_TMR_MSB = 4'h6;
  localparam logic [3:0] CFG_RESET = 4'h7;
  localparam logic [3:0] CFG_DEVICE_CONFIG_REG_B = 4'h8;
  localparam int TMR_EN = 0;
  localparam int TMR_EXT = 1;
  localparam int INT1_TMR = 0;
  localparam int INT1_WAKE = 1;
  localparam int DEVICE_CONFIG_REG_B_BCAST = 0;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [15:0] TMR_RELOAD_RST = 16'hFFFF;
endpackage

//--- verif/host_front_asserts.sv
// port checks for the host front end
module host_front_asserts
  import uart_front_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic bus_style,
  input wire logic [NUM_CH-1:0] rx,
  input wire logic [NUM_CH-1:0] rts_n,
  input wire logic [NUM_CH-1:0] dtr_n,
  input wire logic [NUM_CH-1:0] rx_to_decoder,
  input wire logic [NUM_CH-1:0] ir_mode,
  input wire logic [NUM_CH-1:0] baud_clk_en,
  input wire logic [DW-1:0] data_out,
  input wire logic data_oe,
  input wire logic timer_pending
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic rd_act;
  logic wr_act;
  logic rd_prev;
  logic int1_rd;
  logic [2:0] quiet;
  assign rd_act = !cs_n && (bus_style ? !read_strobe_n : write_strobe_n);
  assign wr_act = !cs_n && !write_strobe_n;
  assign int1_rd = rd_act && !rd_prev && addr == {4'h8, CFG_INT1};
  // soft reset and strap reload land up to three cycles after a write
  always_ff @(posedge mclk) begin
    rd_prev <= rd_act;
    if (!rst_n || wr_act)
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;
  end
  a_oe_on_read: assert property (rd_act |=> data_oe)
    else $error("data_oe missing after read start");
  a_oe_off_idle: assert property (!rd_act |=> !data_oe)
    else $error("data_oe without read");
  a_out_holds: assert property ($changed(data_out) && $past(rst_n)
    |-> $past(rd_act && !rd_prev))
    else $error("data_out moved without read");
  a_reset_outs: assert property (@(posedge mclk) disable iff (1'b0)
    !rst_n |=> rts_n == 8'hFF && dtr_n == 8'hFF && baud_clk_en == 8'h00
    && !data_oe && !timer_pending)
    else $error("outputs not at reset defaults");
  a_modem_quiet: assert property (quiet >= 3'h4 |-> $stable(rts_n)
    && $stable(dtr_n) && $stable(ir_mode))
    else $error("modem outputs moved without write");
  a_rx_invert: assert property (quiet >= 3'h4
    |-> $stable(rx ^ rx_to_decoder))
    else $error("rx inversion moved without write");
  a_div_four: assert property (quiet >= 3'h6 && $fell(baud_clk_en[0])
    |-> !baud_clk_en[0] [*3] ##1 baud_clk_en[0])
    else $error("prescaler not one in four");
  a_pend_clear: assert property ($fell(timer_pending) && $past(rst_n)
    |-> $past(int1_rd) || $past(int1_rd, 2))
    else $error("timer pending cleared without read");
endmodule

//--- verif/host_model.sv
// host processor model on the parallel bus
module host_model
  import uart_front_pkg::*;
(
  input wire logic mclk,
  input wire logic [DW-1:0] data_out,
  output logic cs_n,
  output logic [ADDR_W-1:0] addr,
  output logic [DW-1:0] data_in,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic bus_style
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'b1;
    addr = 8'h00;
    data_in = 8'h00;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    bus_style = 1'b1;
  end
  // style settles a cycle ahead so no strobe is misread
  task automatic access(input logic sep, input logic rnw,
      input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge mclk);
    bus_style <= sep;
    @(posedge mclk);
    cs_n <= 1'b0;
    addr <= a;
    data_in <= wd;
    read_strobe_n <= !(sep && rnw);
    write_strobe_n <= rnw;
    repeat (2) @(posedge mclk);
    rd = data_out;
    cs_n <= 1'b1;
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    // released lines must not look like held data
    data_in <= ~wd;
  endtask
endmodule

//--- verif/testbench.sv
// bench for the host front end
module testbench
  import uart_front_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, rs_n, ws_n, style, oe, tpend;
  logic strap = 1'b1;
  logic wake = 1'b0;
  logic [7:0] addr, din, dout, rts_n, dtr_n, rxd, irm, bce, rxr;
  logic [7:0] rx = 8'hFF;
  logic [7:0] cts_n = 8'hFF;
  logic [7:0] ri_n = 8'hFF;
  logic [7:0] push = 8'h00;
  logic [63:0] rxb = 64'h0;
  logic [7:0] txv;
  logic [7:0] txp = 8'h00;
  logic [63:0] txb;
  logic tclk = 1'b0;
  logic [7:0] dsr_n = 8'hFF;
  logic [7:0] cd_n = 8'hFF;
  int err_count = 0;
  int num_checks = 0;
  always #10 mclk = ~mclk;
  uart_host_front #(.DEPTH(4)) DUT (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n),
    .addr(addr), .data_in(din), .data_out(dout), .data_oe(oe),
    .read_strobe_n(rs_n), .write_strobe_n(ws_n), .bus_style(style),
    .ir_startup_strap(strap), .timer_ext_clock(tclk), .wake_event(wake),
    .rx(rx), .cts_n(cts_n), .dsr_n(dsr_n), .cd_n(cd_n), .ri_n(ri_n),
    .rts_n(rts_n), .dtr_n(dtr_n), .rx_to_decoder(rxd), .ir_mode(irm),
    .baud_clk_en(bce), .tx_byte(txb), .tx_valid(txv), .tx_pop(txp),
    .rx_byte(rxb), .rx_push(push), .rx_ready(rxr), .timer_pending(tpend));
  host_model host (.mclk(mclk), .data_out(dout), .cs_n(cs_n), .addr(addr),
    .data_in(din), .read_strobe_n(rs_n), .write_strobe_n(ws_n),
    .bus_style(style));
  task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic sep, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] tmp;
    host.access(sep, 1'b0, a, d, tmp);
  endtask
  task automatic rd(input logic sep, input logic [7:0] a,
      input logic [7:0] exp, input string what);
    logic [7:0] got;
    host.access(sep, 1'b1, a, 8'h00, got);
    chk(what, exp, got);
  endtask
  task automatic end_sim;
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_reset(input logic [7:0] ir_exp);
    chk("rts_n", 8'hFF, rts_n);
    chk("dtr_n", 8'hFF, dtr_n);
    chk("ir_mode", ir_exp, irm);
  endtask
  task automatic t_select;
    for (int c = 0; c < 8; c++) begin
      wr(c[0], {1'b0, c[2:0], CH_MCR}, 8'h02);
      chk("rts_n", 8'hFF << (c + 1), rts_n);
      chk("dtr_n", 8'hFF, dtr_n);
      rd(!c[0], {1'b0, c[2:0], CH_MCR}, 8'h02, "mcr");
    end
    wr(1'b1, {4'h8, CFG_INT1}, 8'h00);
    chk("rts_n", 8'h00, rts_n);
    wr(1'b1, {4'h8, CFG_DEVICE_CONFIG_REG_B}, 8'h01);
    wr(1'b0, 8'h31, 8'h01);
    chk("dtr_n", 8'h00, dtr_n);
    rd(1'b1, 8'h71, 8'h01, "mcr7");
    wr(1'b1, {4'h8, CFG_DEVICE_CONFIG_REG_B}, 8'h00);
  endtask
  task automatic t_soft;
    wr(1'b1, {4'h8, CFG_RESET}, 8'h0F);
    repeat (3) @(posedge mclk);
    chk("dtr_n", 8'h0F, dtr_n);
    chk("ir_mode", 8'h0F, irm);
    rd(1'b1, 8'h01, 8'h40, "mcr0");
    rd(1'b1, 8'h41, 8'h01, "mcr4");
  endtask
  task automatic t_lines;
    wr(1'b1, {4'h5, CH_FEATURE_CONTROL_REG}, 8'h10);
    chk("rxd", 8'hDF, rxd);
    @(posedge mclk);
    rx <= 8'h00;
    cts_n <= 8'hFE;
    ri_n <= 8'hFD;
    dsr_n <= 8'hFB;
    cd_n <= 8'hF7;
    @(posedge mclk);
    chk("rxd", 8'h20, rxd);
    rd(1'b1, {4'h0, CH_MSR}, 8'h10, "msr0");
    rd(1'b0, {4'h1, CH_MSR}, 8'h40, "msr1");
    rd(1'b1, {4'h2, CH_MSR}, 8'h20, "msr2");
    rd(1'b0, {4'h3, CH_MSR}, 8'h80, "msr3");
  endtask
  task automatic t_tx;
    for (int i = 0; i < 5; i++)
      wr(i[0], {4'h2, CH_DATA}, 8'hA0 + i[7:0]);
    chk("tx_valid", 8'h04, txv);
    rd(1'b1, {4'h2, CH_LSR}, 8'h02, "lsr2 full");
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      chk("tx_byte", 8'hA0 + i[7:0], txb[23:16]);
      txp <= 8'h04;
      @(posedge mclk);
      txp <= 8'h00;
    end
    @(posedge mclk);
    chk("tx_valid", 8'h00, txv);
    rd(1'b1, {4'h2, CH_LSR}, 8'h20, "lsr2 empty");
  endtask
  task automatic t_fifo;
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      rxb[31:24] <= 8'h10 + i[7:0];
      push <= 8'h08;
      @(posedge mclk);
      push <= 8'h00;
    end
    chk("rx_ready", 8'hF7, rxr);
    rd(1'b1, {4'h8, CFG_INT0}, 8'h08, "int0");
    for (int i = 0; i < 4; i++)
      rd(1'b1, {4'h3, CH_DATA}, 8'h10 + i[7:0], "rx_data");
    rd(1'b1, {4'h8, CFG_INT0}, 8'h00, "int0");
  endtask
  task automatic t_timer;
    wr(1'b1, {4'h8, CFG_TMR_LSB}, 8'h03);
    wr(1'b1, {4'h8, CFG_TMR_MSB}, 8'h00);
    wr(1'b1, {4'h8, CFG_TMR_CTL}, 8'h01);
    for (int i = 0; i < 100 && tpend !== 1'b1; i++)
      @(posedge mclk);
    if (tpend !== 1'b1) begin
      err_count++;
      end_sim();
    end
    wr(1'b1, {4'h8, CFG_TMR_CTL}, 8'h00);
    wake <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    rd(1'b1, {4'h8, CFG_INT1}, 8'h03, "int1");
    chk("pending", 8'h00, {7'h0, tpend});
    // external source: mclk alone must not count
    wr(1'b1, {4'h8, CFG_TMR_CTL}, 8'h03);
    repeat (8) @(posedge mclk);
    chk("ext idle", 8'h00, {7'h0, tpend});
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      tclk <= 1'b1;
      @(posedge mclk);
      tclk <= 1'b0;
      if (i == 2)
        chk("ext early", 8'h00, {7'h0, tpend});
    end
    @(posedge mclk);
    chk("ext pending", 8'h01, {7'h0, tpend});
    rd(1'b1, {4'h8, CFG_INT1}, 8'h01, "int1 ext");
    wr(1'b1, {4'h8, CFG_TMR_CTL}, 8'h00);
  endtask
  task automatic t_presc;
    int n0 = 0;
    int n4 = 0;
    wr(1'b1, {4'h0, CH_MCR}, 8'h80);
    repeat (8) @(posedge mclk);
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      n0 += bce[0];
      n4 += bce[4];
    end
    chk("div4", 8'd4, n0[7:0]);
    chk("div1", 8'd16, n4[7:0]);
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset(8'hFF);
    t_select();
    t_soft();
    t_lines();
    t_fifo();
    t_tx();
    t_timer();
    t_presc();
    // strap low across the second reset shows it is really sampled
    strap <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset(8'h00);
    end_sim();
  end
endmodule
bind uart_host_front host_front_asserts chk (.mclk(mclk), .rst_n(rst_n),
  .cs_n(cs_n), .addr(addr), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n), .bus_style(bus_style), .rx(rx),
  .rts_n(rts_n), .dtr_n(dtr_n), .rx_to_decoder(rx_to_decoder),
  .ir_mode(ir_mode), .baud_clk_en(baud_clk_en), .data_out(data_out),
  .data_oe(data_oe), .timer_pending(timer_pending));

//--- verilog/uart_channel.sv
// one uart channel register set with its transmit and receive fifos
module uart_channel
  import uart_front_pkg::*;
#(
  parameter int IDX = 0,
  parameter int DEPTH = FIFO_DEPTH
) (
  chan_bus_if.chan bus,
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rx,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic cd_n,
  input wire logic ri_n,
  output logic rts_n,
  output logic dtr_n,
  output logic rx_dec,
  output logic ir_mode,
  output logic psc_tick,
  output logic [DW-1:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_pop,
  input wire logic [DW-1:0] rx_byte,
  input wire logic rx_push,
  output logic rx_ready
);
  localparam int PW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [DW-1:0] modem_control_reg;
  logic [DW-1:0] feature_control_reg;
  logic [1:0] psc_cnt;
  logic [DW-1:0] head [2];
  logic fresh;
  logic [1:0] full;
  logic [1:0] empty;
  logic [1:0] push;
  logic [1:0] pop;
  logic [DW-1:0] din [2];

  wire clr = !rst_n || bus.soft_rst[IDX];
  wire wr_data = bus.wr[IDX] && bus.addr == CH_DATA;
  wire rd_data = bus.rd[IDX] && bus.addr == CH_DATA;
  // fifo 0 carries transmit bytes, fifo 1 received bytes
  assign push = {rx_push && !full[1], wr_data && !full[0]};
  assign pop = {rd_data && !empty[1], tx_pop && !empty[0]};
  assign din[0] = bus.wdata;
  assign din[1] = rx_byte;

  for (genvar f = 0; f < 2; f++) begin : g_fifo
    logic [DW-1:0] mem [DEPTH];
    logic [PW:0] wptr;
    logic [PW:0] rptr;
    assign empty[f] = wptr == rptr;
    assign full[f] = wptr == {~rptr[PW], rptr[PW-1:0]};
    assign head[f] = mem[rptr[PW-1:0]];
    always_ff @(posedge mclk) begin
      if (clr) begin
        wptr <= '0;
        rptr <= '0;
      end else begin
        if (push[f]) wptr <= wptr + 1'b1;
        if (pop[f]) rptr <= rptr + 1'b1;
      end
      if (push[f]) mem[wptr[PW-1:0]] <= din[f];
    end
  end

  // marks a channel cleared last cycle, so a masked soft reset
  // reloads the strap only where it cleared the modem bits
  always_ff @(posedge mclk) begin
    fresh <= clr;
  end

  always_ff @(posedge mclk) begin
    if (clr) begin
      modem_control_reg <= MCR_RST;
      feature_control_reg <= FEATURE_CONTROL_REG_RST;
    end else begin
      if (bus.wr[IDX] && bus.addr == CH_MCR) modem_control_reg <= bus.wdata;
      if (bus.wr[IDX] && bus.addr == CH_FEATURE_CONTROL_REG) feature_control_reg <= bus.wdata;
      // strap copy follows every reset, never a host write
      if (bus.strap_load && fresh) modem_control_reg[MCR_IR] <= bus.strap;
    end
  end

  always_ff @(posedge mclk) begin
    if (clr) begin
      psc_cnt <= '0;
      psc_tick <= 1'b0;
    end else begin
      psc_cnt <= psc_cnt + 1'b1;
      psc_tick <= !modem_control_reg[MCR_PSC] || psc_cnt == PSC_DIV4_LAST;
    end
  end

  // modem outputs are plain control bits, usable as general outputs
  assign rts_n = !modem_control_reg[MCR_RTS];
  assign dtr_n = !modem_control_reg[MCR_DTR];
  assign rx_dec = rx ^ feature_control_reg[FEATURE_CONTROL_REG_RXINV];
  assign ir_mode = modem_control_reg[MCR_IR];
  assign tx_byte = head[0];
  assign tx_valid = !empty[0];
  assign rx_ready = !full[1];
  assign bus.pend[IDX] = !empty[1];

  wire [DW-1:0] msr = {!cd_n, !ri_n, !dsr_n, !cts_n, 4'h0};
  wire [DW-1:0] lsr = {2'h0, empty[0], 3'h0, full[0], !empty[1]};
  wire [DW-1:0] rx_head = head[1];
  assign bus.rdata[IDX] =
    bus.addr == CH_DATA ? rx_head :
    bus.addr == CH_MCR ? modem_control_reg :
    bus.addr == CH_FEATURE_CONTROL_REG ? feature_control_reg :
    bus.addr == CH_MSR ? msr :
    bus.addr == CH_LSR ? lsr : 8'h00;
endmodule

//--- verilog/uart_host_front.sv
// host port front end: bus decode, resets, strap and device config
// What this block does
// - with chip select low and address bit 7 clear, bits 6:4 pick the channel.
// - hardware reset returns all channel registers and outputs to defaults.
// - a write to the reset register resets channel registers without rst_n.
// - the infrared strap is sampled after every reset into modem bit 6.
// - bus style high means separate strobes, low means one strobe plus R/W.
// - feature control bit 4 inverts the received infrared pulse.
// - a 16-bit timer may count an external clock instead of mclk.
// - rts and dtr outputs are active low and software driven.
// - cts, dsr, cd and ri are active low and readable as inputs.
// - of four interrupt source registers, two show channel, timer and wake status.
// - each channel has a 32-byte transmit and a 32-byte receive fifo.
// - each channel prescaler divides the clock by one or by four.
// - with config b bit 0 set, a channel write reaches all eight channels.
module uart_host_front
  import uart_front_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DW-1:0] data_in,
  output logic [DW-1:0] data_out,
  output logic data_oe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic bus_style,
  input wire logic ir_startup_strap,
  input wire logic timer_ext_clock,
  input wire logic wake_event,
  input wire logic [NUM_CH-1:0] rx,
  input wire logic [NUM_CH-1:0] cts_n,
  input wire logic [NUM_CH-1:0] dsr_n,
  input wire logic [NUM_CH-1:0] cd_n,
  input wire logic [NUM_CH-1:0] ri_n,
  output logic [NUM_CH-1:0] rts_n,
  output logic [NUM_CH-1:0] dtr_n,
  output logic [NUM_CH-1:0] rx_to_decoder,
  output logic [NUM_CH-1:0] ir_mode,
  output logic [NUM_CH-1:0] baud_clk_en,
  output logic [NUM_CH*DW-1:0] tx_byte,
  output logic [NUM_CH-1:0] tx_valid,
  input wire logic [NUM_CH-1:0] tx_pop,
  input wire logic [NUM_CH*DW-1:0] rx_byte,
  input wire logic [NUM_CH-1:0] rx_push,
  output logic [NUM_CH-1:0] rx_ready,
  output logic timer_pending
);
  chan_bus_if bus ();

  logic rd_act_d;
  logic wr_act_d;
  logic strap_pending;
  logic [DW-1:0] device_config_reg_b;
  logic [DW-1:0] tmr_ctl;
  logic [TMR_W-1:0] tmr_reload;
  logic [TMR_W-1:0] tmr_cnt;
  logic ext_clk_d;
  logic wake_pending;
  logic [NUM_CH-1:0] soft_rst;

  // separate strobes, or cs as strobe with write_strobe_n as R/W
  wire sel = !cs_n;
  wire rd_act = sel &&
    (bus_style ? !read_strobe_n : write_strobe_n);
  wire wr_act = sel && !write_strobe_n;
  // one access per strobe: act only on the leading cycle
  wire rd_go = rd_act && !rd_act_d;
  wire wr_go = wr_act && !wr_act_d;

  wire to_cfg = addr[ADDR_CFG_BIT];
  wire [2:0] ch_num = addr[ADDR_CH_HI:ADDR_CH_LO];
  wire [REG_AW-1:0] reg_off = addr[REG_AW-1:0];
  wire [NUM_CH-1:0] ch_hot = NUM_CH'(1) << ch_num;
  wire bcast = device_config_reg_b[DEVICE_CONFIG_REG_B_BCAST];
  wire cfg_wr = wr_go && to_cfg;
  wire cfg_rd = rd_go && to_cfg;

  assign bus.wr = (wr_go && !to_cfg) ?
    (bcast ? {NUM_CH{1'b1}} : ch_hot) : '0;
  assign bus.rd = (rd_go && !to_cfg) ? ch_hot : '0;
  assign bus.addr = reg_off;
  assign bus.wdata = data_in;
  assign bus.soft_rst = soft_rst;
  assign bus.strap_load = strap_pending;
  assign bus.strap = ir_startup_strap;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_act_d <= 1'b0;
      wr_act_d <= 1'b0;
    end else begin
      rd_act_d <= rd_act;
      wr_act_d <= wr_act;
    end
  end

  // soft reset clears the selected channels for one cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      soft_rst <= '0;
    end else begin
      soft_rst <= (cfg_wr && reg_off == CFG_RESET) ? data_in : '0;
    end
  end

  // strap is caught the cycle after either reset ends, never under it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      strap_pending <= 1'b1;
    end else begin
      strap_pending <= |soft_rst;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      device_config_reg_b <= CFG_RST;
      tmr_ctl <= CFG_RST;
      tmr_reload <= TMR_RELOAD_RST;
    end else if (cfg_wr) begin
      if (reg_off == CFG_DEVICE_CONFIG_REG_B) device_config_reg_b <= data_in;
      if (reg_off == CFG_TMR_CTL) tmr_ctl <= data_in;
      if (reg_off == CFG_TMR_LSB) tmr_reload[7:0] <= data_in;
      if (reg_off == CFG_TMR_MSB) tmr_reload[15:8] <= data_in;
    end
  end

  // external timer clock is taken as synchronous and edge detected
  wire ext_rise = timer_ext_clock && !ext_clk_d;
  wire tmr_tick = tmr_ctl[TMR_EN] &&
    (tmr_ctl[TMR_EXT] ? ext_rise : 1'b1);
  wire tmr_zero = tmr_cnt == '0;
  wire int1_rd = cfg_rd && reg_off == CFG_INT1;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ext_clk_d <= 1'b0;
      tmr_cnt <= TMR_RELOAD_RST;
      timer_pending <= 1'b0;
      wake_pending <= 1'b0;
    end else begin
      ext_clk_d <= timer_ext_clock;
      if (!tmr_ctl[TMR_EN]) tmr_cnt <= tmr_reload;
      else if (tmr_tick) tmr_cnt <= tmr_zero ? tmr_reload : tmr_cnt - 1'b1;
      // reading the source register clears it; a new event wins
      if (tmr_tick && tmr_zero) timer_pending <= 1'b1;
      else if (int1_rd) timer_pending <= 1'b0;
      if (wake_event) wake_pending <= 1'b1;
      else if (int1_rd) wake_pending <= 1'b0;
    end
  end

  wire [DW-1:0] int1 = {6'h00, wake_pending, timer_pending};
  wire [DW-1:0] cfg_rdata =
    reg_off == CFG_INT0 ? bus.pend :
    reg_off == CFG_INT1 ? int1 :
    reg_off == CFG_INT2 ? 8'h00 :
    reg_off == CFG_INT3 ? 8'h00 :
    reg_off == CFG_TMR_CTL ? tmr_ctl :
    reg_off == CFG_TMR_LSB ? tmr_cnt[7:0] :
    reg_off == CFG_TMR_MSB ? tmr_cnt[15:8] :
    reg_off == CFG_DEVICE_CONFIG_REG_B ? device_config_reg_b : 8'h00;
  wire [DW-1:0] rdata_mux = to_cfg ? cfg_rdata : bus.rdata[ch_num];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_out <= '0;
      data_oe <= 1'b0;
    end else begin
      if (rd_go) data_out <= rdata_mux;
      data_oe <= rd_act;
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    uart_channel #(.IDX(c), .DEPTH(DEPTH)) u_ch (
      .bus(bus.chan),
      .mclk(mclk),
      .rst_n(rst_n),
      .rx(rx[c]),
      .cts_n(cts_n[c]),
      .dsr_n(dsr_n[c]),
      .cd_n(cd_n[c]),
      .ri_n(ri_n[c]),
      .rts_n(rts_n[c]),
      .dtr_n(dtr_n[c]),
      .rx_dec(rx_to_decoder[c]),
      .ir_mode(ir_mode[c]),
      .psc_tick(baud_clk_en[c]),
      .tx_byte(tx_byte[c*DW +: DW]),
      .tx_valid(tx_valid[c]),
      .tx_pop(tx_pop[c]),
      .rx_byte(rx_byte[c*DW +: DW]),
      .rx_push(rx_push[c]),
      .rx_ready(rx_ready[c])
    );
  end
endmodule
